// ### inc/clock_ctrl_pkg.sv
package clock_ctrl_pkg;
  // ------------------------------------------------
  // register offsets
  // ------------------------------------------------
  localparam logic [7:0] SYS_ON_ADDR = 8'h00;
  localparam logic [7:0] SYS_OFF_ADDR = 8'h04;
  localparam logic [7:0] SYS_STATE_ADDR = 8'h08;
  localparam logic [7:0] PER_ON_ADDR = 8'h10;
  localparam logic [7:0] PER_OFF_ADDR = 8'h14;
  localparam logic [7:0] PER_STATE_ADDR = 8'h18;
  localparam logic [7:0] OSC_CTRL_ADDR = 8'h20;
  localparam logic [7:0] MEASURE_ADDR = 8'h24;
  localparam logic [7:0] PLL1_ADDR = 8'h28;
  localparam logic [7:0] PLL2_ADDR = 8'h2c;
  localparam logic [7:0] STATUS_ADDR = 8'h68;
  // ------------------------------------------------
  // field masks and positions
  // ------------------------------------------------
  localparam logic [31:0] SYS_MASK = 32'h0000_0f17;
  localparam logic [31:0] SYS_RESET = 32'h0000_0001;
  localparam logic [31:0] PER_MASK = 32'hffff_fffc;
  localparam logic [31:0] OSC_MASK = 32'h0000_ff01;
  localparam logic [31:0] PLL1_MASK = 32'h07ff_ffff;
  localparam logic [31:0] PLL2_MASK = 32'h17ff_ffff;
  localparam logic [31:0] PLL_RESET = 32'h0000_3f00;
  localparam int OSC_EN_BIT = 0;
  localparam int OSC_CNT_LSB = 8;
  localparam int PLL_DIV_LSB = 0;
  localparam int PLL_CNT_LSB = 8;
  localparam int PLL_RANGE_LSB = 14;
  localparam int PLL_MUL_LSB = 16;
  localparam int USB_HALF_BIT = 28;
  localparam int OSC_STABLE_BIT = 0;
  localparam int LOCK1_BIT = 1;
  localparam int LOCK2_BIT = 2;
  localparam int VALID_BIT = 16;
  localparam logic [4:0] MEASURE_PERIODS = 5'h10;
  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b00,
    MEAS_ALIGN = 2'b01,
    MEAS_RUN = 2'b10,
    MEAS_DONE = 2'b11
  } meas_state_t;
endpackage : clock_ctrl_pkg

// ### hdl/lock_counter.sv
`timescale 1ns/1ns
// slow-clock down counter for a pll lock or oscillator start-up
module lock_counter
  import clock_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [7:0] count,
  input wire logic slowTick,
  output logic done
);
  logic [7:0] remain_ff;
  logic done_ff;
  assign done = done_ff;
  // load clears the flag and reloads; the flag rises at zero
  always_ff @(posedge clk) begin
    if (reset) begin
      remain_ff <= 8'h00;
      done_ff <= 1'b0;
    end else if (load) begin
      remain_ff <= count;
      done_ff <= 1'b0;
    end else if (!done_ff && remain_ff == 8'h00) begin
      done_ff <= 1'b1;
    end else if (slowTick && !done_ff) begin
      remain_ff <= remain_ff - 8'h01;
    end
  end
endmodule : lock_counter

// ### hdl/freq_meter.sv
`timescale 1ns/1ns
// counts main clock edges within 16 slow periods
module freq_meter
  import clock_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic slowTick,
  input wire logic mainTick,
  output logic [15:0] result,
  output logic valid
);
  meas_state_t state_ff;
  meas_state_t nxt_state;
  logic [4:0] periods_ff;
  logic [15:0] count_ff;
  logic [15:0] result_ff;
  logic valid_ff;
  assign result = result_ff;
  assign valid = valid_ff;
  // window sequencing starts on a slow edge for a clean count
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MEAS_IDLE: if (enable) nxt_state = MEAS_ALIGN;
      MEAS_ALIGN: if (slowTick) nxt_state = MEAS_RUN;
      MEAS_RUN: if (slowTick && periods_ff == MEASURE_PERIODS - 5'h01) nxt_state = MEAS_DONE;
      MEAS_DONE: nxt_state = MEAS_DONE;
      default: nxt_state = MEAS_IDLE;
    endcase
    if (!enable) nxt_state = MEAS_IDLE;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= MEAS_IDLE;
      periods_ff <= 5'h00;
      count_ff <= 16'h0000;
      result_ff <= 16'h0000;
      valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff != MEAS_RUN) begin
        periods_ff <= 5'h00;
        count_ff <= 16'h0000;
      end else begin
        if (slowTick) periods_ff <= periods_ff + 5'h01;
        if (mainTick) count_ff <= count_ff + 16'h0001;
      end
      if (state_ff == MEAS_RUN && nxt_state == MEAS_DONE) begin
        result_ff <= count_ff + {15'h0000, mainTick};
      end
      valid_ff <= enable && (state_ff == MEAS_DONE);
    end
  end
endmodule : freq_meter

// ### hdl/clock_gating_and_pll_config.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
// register side of the clock controller
module clock_gating_and_pll_config
  import clock_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [31:0] rdData,
  input wire logic slowTick,
  input wire logic mainTick,
  output logic cpu_clock_gate,
  output logic usb_device_clock_gate,
  output logic usb_device_suspend_autogate,
  output logic usb_host_clock_gate,
  output logic [3:0] prog_clock_output_gates,
  output logic [31:0] peripheral_gate_bits,
  output logic oscillator_enable,
  output logic oscOutputDrive,
  output logic [7:0] first_pll_divider,
  output logic [1:0] first_pll_range,
  output logic [10:0] first_pll_multiplier,
  output logic firstPllActive,
  output logic [7:0] second_pll_divider,
  output logic [1:0] second_pll_range,
  output logic [10:0] second_pll_multiplier,
  output logic secondPllActive,
  output logic usb_half_rate_select,
  output logic rangeFault
);
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  // a write-1-to-set / write-1-to-clear update of a masked state word
  function automatic logic [31:0] setClear(input logic [31:0] cur, input logic [31:0] setBits,
      input logic [31:0] clrBits, input logic [31:0] mask);
    setClear = ((cur | setBits) & ~clrBits) & mask;
  endfunction : setClear
  // only codes 00 and 10 are legal ranges
  function automatic logic rangeBad(input logic [1:0] code);
    rangeBad = code[0];
  endfunction : rangeBad

  // ------------------------------------------------
  // decode
  // ------------------------------------------------
  wire sysOnWr = wrStrobe && addr == SYS_ON_ADDR;
  wire sysOffWr = wrStrobe && addr == SYS_OFF_ADDR;
  wire perOnWr = wrStrobe && addr == PER_ON_ADDR;
  wire perOffWr = wrStrobe && addr == PER_OFF_ADDR;
  wire oscWr = wrStrobe && addr == OSC_CTRL_ADDR;
  wire pll1Wr = wrStrobe && addr == PLL1_ADDR;
  wire pll2Wr = wrStrobe && addr == PLL2_ADDR;

  // ------------------------------------------------
  // state registers
  // ------------------------------------------------
  logic [31:0] sys_ff;
  logic [31:0] per_ff;
  logic [31:0] osc_ff;
  logic [31:0] pll1_ff;
  logic [31:0] pll2_ff;
  logic [31:0] rdData_ff;
  logic [31:0] nxt_sys;
  logic [31:0] nxt_per;

  // set and clear in the same write never collide: strobes hit one address
  assign nxt_sys = setClear(sys_ff, sysOnWr ? wrData : 32'h0000_0000,
      sysOffWr ? wrData : 32'h0000_0000, SYS_MASK);
  assign nxt_per = setClear(per_ff, perOnWr ? wrData : 32'h0000_0000,
      perOffWr ? wrData : 32'h0000_0000, PER_MASK);

  always_ff @(posedge clk) begin
    if (reset) begin
      sys_ff <= SYS_RESET;
      per_ff <= 32'h0000_0000;
      osc_ff <= 32'h0000_0000;
      pll1_ff <= PLL_RESET;
      pll2_ff <= PLL_RESET;
    end else begin
      sys_ff <= nxt_sys;
      per_ff <= nxt_per;
      if (oscWr) osc_ff <= wrData & OSC_MASK;
      if (pll1Wr) pll1_ff <= wrData & PLL1_MASK;
      if (pll2Wr) pll2_ff <= wrData & PLL2_MASK;
    end
  end

  // ------------------------------------------------
  // oscillator start-up, measurement, lock counters
  // ------------------------------------------------
  logic oscStable;
  logic lock1;
  logic lock2;
  logic [15:0] mainCount;
  logic mainValid;

  // oscillator stability needs the enable as well as the elapsed count
  logic oscDone;
  assign oscStable = oscDone && osc_ff[OSC_EN_BIT];

  lock_counter osc_wait (
    .clk(clk),
    .reset(reset),
    .load(oscWr),
    .count(wrData[OSC_CNT_LSB +: 8]),
    .slowTick(slowTick),
    .done(oscDone)
  );

  lock_counter pll1_lock (
    .clk(clk),
    .reset(reset),
    .load(pll1Wr),
    .count(wrData[PLL_CNT_LSB +: 6] == 6'h00 ? 8'h00 : {2'b00, wrData[PLL_CNT_LSB +: 6]}),
    .slowTick(slowTick),
    .done(lock1)
  );

  lock_counter pll2_lock (
    .clk(clk),
    .reset(reset),
    .load(pll2Wr),
    .count({2'b00, wrData[PLL_CNT_LSB +: 6]}),
    .slowTick(slowTick),
    .done(lock2)
  );

  freq_meter meter (
    .clk(clk),
    .reset(reset),
    .enable(oscStable),
    .slowTick(slowTick),
    .mainTick(mainTick),
    .result(mainCount),
    .valid(mainValid)
  );

  // ------------------------------------------------
  // outputs to the clock tree
  // ------------------------------------------------
  assign cpu_clock_gate = sys_ff[0];
  assign usb_device_clock_gate = sys_ff[1];
  assign usb_device_suspend_autogate = sys_ff[2];
  assign usb_host_clock_gate = sys_ff[4];
  assign prog_clock_output_gates = sys_ff[11:8];
  assign peripheral_gate_bits = per_ff;
  assign oscillator_enable = osc_ff[OSC_EN_BIT];
  assign oscOutputDrive = osc_ff[OSC_EN_BIT];
  // divider 0 gives no output, 1 bypass, others divide; the analog pll applies it
  assign first_pll_divider = pll1_ff[PLL_DIV_LSB +: 8];
  assign first_pll_range = pll1_ff[PLL_RANGE_LSB +: 2];
  assign first_pll_multiplier = pll1_ff[PLL_MUL_LSB +: 11];
  // a zero divider or multiplier leaves the pll stopped
  assign firstPllActive = |first_pll_multiplier && |first_pll_divider;
  assign second_pll_divider = pll2_ff[PLL_DIV_LSB +: 8];
  assign second_pll_range = pll2_ff[PLL_RANGE_LSB +: 2];
  assign second_pll_multiplier = pll2_ff[PLL_MUL_LSB +: 11];
  assign secondPllActive = |second_pll_multiplier && |second_pll_divider;
  assign usb_half_rate_select = pll2_ff[USB_HALF_BIT];
  // reserved range codes are flagged rather than silently accepted
  assign rangeFault = rangeBad(first_pll_range) || rangeBad(second_pll_range);

  // ------------------------------------------------
  // read path
  // ------------------------------------------------
  logic [31:0] statusWord;
  logic [31:0] measureWord;
  logic [31:0] rdMux;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[OSC_STABLE_BIT] = oscStable;
    statusWord[LOCK1_BIT] = lock1 && firstPllActive;
    statusWord[LOCK2_BIT] = lock2 && secondPllActive;
    measureWord = 32'h0000_0000;
    measureWord[15:0] = mainCount;
    measureWord[VALID_BIT] = mainValid && osc_ff[OSC_EN_BIT];
  end
  // unmapped and write-only addresses read as zero
  assign rdMux = (addr == SYS_STATE_ADDR) ? sys_ff :
                 (addr == PER_STATE_ADDR) ? per_ff :
                 (addr == OSC_CTRL_ADDR) ? osc_ff :
                 (addr == MEASURE_ADDR) ? measureWord :
                 (addr == PLL1_ADDR) ? pll1_ff :
                 (addr == PLL2_ADDR) ? pll2_ff :
                 (addr == STATUS_ADDR) ? statusWord : 32'h0000_0000;
  // data stand one cycle after the read strobe only
  always_ff @(posedge clk) begin
    if (reset) rdData_ff <= 32'h0000_0000;
    else rdData_ff <= rdStrobe ? rdMux : 32'h0000_0000;
  end
  assign rdData = rdData_ff;
endmodule : clock_gating_and_pll_config

// ### bench/clock_ctrl_properties.sv
`timescale 1ns/1ns
// ------------------------------------------------
// port checks of the clock controller
// ------------------------------------------------
module clock_ctrl_properties
  import clock_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [31:0] rdData,
  input wire logic cpu_clock_gate,
  input wire logic usb_device_clock_gate,
  input wire logic usb_device_suspend_autogate,
  input wire logic usb_host_clock_gate,
  input wire logic [3:0] prog_clock_output_gates,
  input wire logic [31:0] peripheral_gate_bits,
  input wire logic oscillator_enable,
  input wire logic oscOutputDrive,
  input wire logic [7:0] first_pll_divider,
  input wire logic [1:0] first_pll_range,
  input wire logic [10:0] first_pll_multiplier,
  input wire logic firstPllActive,
  input wire logic [1:0] second_pll_range,
  input wire logic [7:0] second_pll_divider,
  input wire logic [10:0] second_pll_multiplier,
  input wire logic secondPllActive,
  input wire logic usb_half_rate_select,
  input wire logic rangeFault
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // gate levels packed as the sys state word should read back
  wire logic [31:0] sysWord = {20'h0, prog_clock_output_gates, 3'h0, usb_host_clock_gate,
    1'b0, usb_device_suspend_autogate, usb_device_clock_gate, cpu_clock_gate};
  sequence rdAt(logic [7:0] a);
    rdStrobe && addr == a;
  endsequence
  sequence wrAt(logic [7:0] a);
    wrStrobe && addr == a;
  endsequence
  sys_state_read_a: assert property (rdAt(SYS_STATE_ADDR) |=> rdData == sysWord)
    else $error("sys state readback differs from gates");
  per_state_read_a: assert property (rdAt(PER_STATE_ADDR) |=> rdData == peripheral_gate_bits)
    else $error("peripheral state readback differs");
  per_set_a: assert property (wrAt(PER_ON_ADDR) |=>
    (peripheral_gate_bits & $past(wrData) & PER_MASK) == ($past(wrData) & PER_MASK))
    else $error("peripheral enable missed a bit");
  per_clear_a: assert property (wrAt(PER_OFF_ADDR) |=>
    (peripheral_gate_bits & $past(wrData)) == 32'h0)
    else $error("peripheral disable missed a bit");
  // zero bits of either write must leave the gate alone
  per_keep_a: assert property (wrStrobe && (addr == PER_ON_ADDR || addr == PER_OFF_ADDR) |=>
    (peripheral_gate_bits & ~$past(wrData)) == ($past(peripheral_gate_bits) & ~$past(wrData)))
    else $error("peripheral gate changed on a zero bit");
  per_low_zero_a: assert property (peripheral_gate_bits[1:0] == 2'b00)
    else $error("peripheral bits 1:0 not zero");
  osc_enable_a: assert property (wrAt(OSC_CTRL_ADDR) |=> oscillator_enable == $past(wrData[0]))
    else $error("oscillator enable not taken from write");
  pll_fields_a: assert property (wrAt(PLL1_ADDR) |=>
    first_pll_divider == $past(wrData[7:0]) && first_pll_multiplier == $past(wrData[26:16]))
    else $error("first pll fields not taken from write");
  pll_active_a: assert property (firstPllActive ==
    (first_pll_multiplier != 11'h0 && first_pll_divider != 8'h00))
    else $error("first pll active flag wrong");
  usb_half_a: assert property (wrAt(PLL2_ADDR) |=> usb_half_rate_select == $past(wrData[28]))
    else $error("usb half rate select not taken");
  range_fault_a: assert property (rangeFault == (first_pll_range[0] | second_pll_range[0]))
    else $error("reserved range flag wrong");
  prog_on_a: assert property (wrAt(SYS_ON_ADDR) |=>
    (prog_clock_output_gates & $past(wrData[11:8])) == $past(wrData[11:8]))
    else $error("programmable output not enabled");
  // the crystal drive follows the oscillator enable, never the input pin mode
  osc_drive_a: assert property (oscOutputDrive == oscillator_enable)
    else $error("oscillator drive differs from enable");
  pll2_fields_a: assert property (wrAt(PLL2_ADDR) |=>
    second_pll_divider == $past(wrData[7:0]) && second_pll_multiplier == $past(wrData[26:16]))
    else $error("second pll fields not taken from write");
  pll2_active_a: assert property (secondPllActive ==
    (second_pll_multiplier != 11'h0 && second_pll_divider != 8'h00))
    else $error("second pll active flag wrong");
endmodule : clock_ctrl_properties
bind clock_gating_and_pll_config clock_ctrl_properties i_clock_ctrl_properties (.clk, .reset,
  .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .cpu_clock_gate, .usb_device_clock_gate,
  .usb_device_suspend_autogate, .usb_host_clock_gate, .prog_clock_output_gates,
  .peripheral_gate_bits, .oscillator_enable, .oscOutputDrive, .first_pll_divider,
  .first_pll_range, .first_pll_multiplier, .firstPllActive, .second_pll_range,
  .second_pll_divider, .second_pll_multiplier, .secondPllActive, .usb_half_rate_select,
  .rangeFault);

// ### bench/clock_gating_and_pll_config_tb.sv
`timescale 1ns/1ns
module clock_gating_and_pll_config_tb
  import clock_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  logic slowTick = 1'b0;
  logic mainTick = 1'b0;
  logic [2:0] tickCnt = 3'h0;
  logic [31:0] rdData, perBits, d;
  logic halfSel, pllFault, pllOn;
  logic [7:0] a;
  int error_cnt = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  // slow tick every 8 clocks, main tick every 2: 16 slow periods hold 64 main ticks
  always @(posedge clk) begin
    tickCnt <= tickCnt + 3'h1;
    slowTick <= (tickCnt == 3'h7);
    mainTick <= tickCnt[0];
  end
  clock_gating_and_pll_config i_clock_gating_and_pll_config (.clk(clk), .reset(reset),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .slowTick(slowTick), .mainTick(mainTick), .cpu_clock_gate(), .usb_device_clock_gate(),
    .usb_device_suspend_autogate(), .usb_host_clock_gate(), .prog_clock_output_gates(),
    .peripheral_gate_bits(perBits), .oscillator_enable(), .oscOutputDrive(),
    .first_pll_divider(), .first_pll_range(), .first_pll_multiplier(), .firstPllActive(pllOn),
    .second_pll_divider(), .second_pll_range(), .second_pll_multiplier(), .secondPllActive(),
    .usb_half_rate_select(halfSel), .rangeFault(pllFault));
  // ------------------------------------------------
  // bus tasks
  // ------------------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
    @(posedge clk);
    addr <= ad;
    wrData <= dat;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] ad, output logic [31:0] dat);
    @(posedge clk);
    addr <= ad;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 dat = rdData;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] v;
    rd(ad, v);
    chk(v, exp);
  endtask : rdc
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff slowTick);
  endtask : ticks
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  // ------------------------------------------------
  // test sequence
  // ------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rdc(SYS_STATE_ADDR, SYS_RESET);
    rdc(PER_STATE_ADDR, 32'h0);
    rdc(OSC_CTRL_ADDR, 32'h0);
    rdc(PLL1_ADDR, PLL_RESET);
    rdc(PLL2_ADDR, PLL_RESET);
    wr(8'h0c, 32'hffff_ffff);
    rdc(8'h0c, 32'h0);
    wr(SYS_ON_ADDR, 32'hffff_ffff);
    rdc(SYS_STATE_ADDR, SYS_MASK);
    wr(SYS_OFF_ADDR, 32'h0000_0506);
    wr(SYS_ON_ADDR, 32'h0);
    rdc(SYS_STATE_ADDR, 32'h0000_0a11);
    wr(PER_ON_ADDR, 32'hffff_ffff);
    rdc(PER_STATE_ADDR, PER_MASK);
    wr(PER_OFF_ADDR, 32'h5555_0003);
    wr(PER_ON_ADDR, 32'h0);
    rdc(PER_STATE_ADDR, 32'haaaa_fffc);
    chk(perBits, 32'haaaa_fffc);
    // oscillator with a start-up of 2 slow cycles, then poll for the count
    rdc(MEASURE_ADDR, 32'h0);
    wr(OSC_CTRL_ADDR, 32'h0000_0201);
    rdc(OSC_CTRL_ADDR, 32'h0000_0201);
    d = 32'h0;
    for (int i = 0; i < 150 && d[16] !== 1'b1; i++) rd(MEASURE_ADDR, d);
    chk(d, 32'h0001_0040);
    rd(STATUS_ADDR, d);
    chk({31'h0, d[OSC_STABLE_BIT]}, 32'h1);
    wr(OSC_CTRL_ADDR, 32'h0);
    rd(MEASURE_ADDR, d);
    chk({31'h0, d[16]}, 32'h0);
    rd(STATUS_ADDR, d);
    chk({31'h0, d[OSC_STABLE_BIT]}, 32'h0);
    // lock timing with a count of 3 slow cycles on each pll
    for (int i = 0; i < 2; i++) begin
      a = (i == 0) ? PLL1_ADDR : PLL2_ADDR;
      wr(a, 32'h0005_0301);
      ticks(2);
      rd(STATUS_ADDR, d);
      chk({31'h0, d[1 + i]}, 32'h0);
      ticks(2);
      rd(STATUS_ADDR, d);
      chk({31'h0, d[1 + i]}, 32'h1);
      wr(a, 32'h0005_0301);
      rd(STATUS_ADDR, d);
      chk({31'h0, d[1 + i]}, 32'h0);
      wr(a, 32'h0000_0001);
      ticks(1);
      rd(STATUS_ADDR, d);
      chk({31'h0, d[1 + i]}, 32'h0);
    end
    wr(PLL1_ADDR, 32'hffff_ffff);
    rdc(PLL1_ADDR, PLL1_MASK);
    wr(PLL2_ADDR, 32'hffff_ffff);
    rdc(PLL2_ADDR, PLL2_MASK);
    chk({29'h0, halfSel, pllFault, pllOn}, 32'h7);
    wr(PLL1_ADDR, 32'h0005_8000);
    wr(PLL2_ADDR, 32'h0000_8002);
    rdc(PLL2_ADDR, 32'h0000_8002);
    chk({29'h0, halfSel, pllFault, pllOn}, 32'h0);
    end_sim();
  end
endmodule : clock_gating_and_pll_config_tb
